// [design/vpc_map.svh]
// Plane controller register offsets, field positions and reset values
`ifndef VPC_MAP_SVH
`define VPC_MAP_SVH
`define VPC_MASK_REG_ADDR   24'he00007
`define VPC_MASK_LSB        0
`define VPC_MASK_MSB        3
`define VPC_INTERPLANE_BIT  15
`define VPC_MASK_RESET      4'h0
`define VPC_INTERPLANE_RST  1'h0
`define VPC_PLANE_SEL_LO    17
`define VPC_PLANE_SEL_HI    18
`define VPC_VRAM_SEL_BIT    22
`define VPC_IO_SEL_BIT      23
`define VPC_SYNC_STAGES     2
`endif

// [design/vpc_pkg.sv]
// Plane controller shared types
package vpc_pkg;
  localparam int unsigned NumPlanes = 4;

  typedef logic [NumPlanes-1:0] vpc_planes_t;

  // Processor and bus sequencer pins, grouped for synchronising
  typedef struct packed {
    logic        phaseOneClock;
    logic        columnStrobeInN;
    logic        rowStrobeN;
    logic        maskLatchStrobeN;
    logic        refreshTransferActive;
    logic        busStatusHigh;
    logic        busStatusLow;
    logic        bitbltStatusEnable;
    logic        controlRegSelectN;
    vpc_planes_t functionSelectStrobeN;
    logic        readN;
    logic [23:0] address;
    logic [15:0] data;
  } vpc_pins_s;

  // Bus status copy that is held across an interplane source read
  typedef struct packed {
    logic busStatusHigh;
    logic busStatusLow;
    logic bitbltStatusEnable;
  } vpc_status_s;

  // Plane drive outputs
  typedef struct packed {
    vpc_planes_t columnStrobeN;
    vpc_planes_t xcvrEnableN;
    vpc_planes_t xcvrDirection;
  } vpc_drive_s;

  typedef enum logic [1:0] {
    VPC_ACC_LINEAR,
    VPC_ACC_INTERPLANE_SRC,
    VPC_ACC_DRAWING
  } vpc_access_e;
endpackage : vpc_pkg

// [design/vpc_plane_decode.sv]
// Plane controller access decode: next plane strobes and transceiver controls
`timescale 1ns/1ps
`include "vpc_map.svh"
module vpc_plane_decode (
  input  wire vpc_pkg::vpc_status_s status,
  input  wire logic                 interplane,
  input  wire vpc_pkg::vpc_planes_t writeMask,
  input  wire logic [23:0]          address,
  input  wire logic                 refreshTransferActive,
  input  wire logic                 controlRegSelectN,
  input  wire vpc_pkg::vpc_planes_t functionSelectStrobeN,
  input  wire logic                 readN,
  output      vpc_pkg::vpc_access_e access,
  output      vpc_pkg::vpc_planes_t strobeSelect,
  output      vpc_pkg::vpc_planes_t enableN,
  output      vpc_pkg::vpc_planes_t direction
);
  // One-hot plane from the two plane select address lines
  function automatic vpc_pkg::vpc_planes_t planeOneHot(input logic [23:0] a);
    logic [1:0] idx;
    idx = {a[`VPC_PLANE_SEL_HI], a[`VPC_PLANE_SEL_LO]};
    planeOneHot = vpc_pkg::vpc_planes_t'(4'h1 << idx);
  endfunction : planeOneHot

  logic                vramSel;
  vpc_pkg::vpc_planes_t addressed;

  always_comb begin
    vramSel   = ~address[`VPC_IO_SEL_BIT] & address[`VPC_VRAM_SEL_BIT];
    addressed = planeOneHot(address) & {vpc_pkg::NumPlanes{vramSel}};
    if (!status.busStatusHigh) begin
      access = vpc_pkg::VPC_ACC_LINEAR;
    end else if (status.bitbltStatusEnable && !status.busStatusLow && interplane) begin
      access = vpc_pkg::VPC_ACC_INTERPLANE_SRC;
    end else begin
      access = vpc_pkg::VPC_ACC_DRAWING;
    end

    strobeSelect = 4'h0;
    enableN      = 4'hf;
    direction    = 4'h0;
    case (access)
      vpc_pkg::VPC_ACC_LINEAR: begin
        strobeSelect = addressed;
        if (!controlRegSelectN) begin
          enableN = 4'h0;
        end else if (functionSelectStrobeN != 4'hf) begin
          enableN = functionSelectStrobeN;
        end else begin
          enableN   = ~addressed;
          direction = addressed & {vpc_pkg::NumPlanes{~readN}};
        end
      end
      vpc_pkg::VPC_ACC_INTERPLANE_SRC: begin
        strobeSelect = addressed;
        enableN      = 4'h0;
        direction    = addressed;
      end
      vpc_pkg::VPC_ACC_DRAWING: begin
        strobeSelect = writeMask;
        enableN      = 4'hf;
      end
      default: begin
        strobeSelect = 4'h0;
      end
    endcase
    if (refreshTransferActive) begin
      strobeSelect = 4'hf;
    end
  end
endmodule : vpc_plane_decode

// [design/vpc_plane_controller.sv]
// Plane controller top: mask register, status hold, plane strobes and transceivers
//
// Function
// - Latch strobe captures D0-3 mask, D15 flag
// - Drawing: plane strobed only if mask bit set
// - Strobes follow column input, on phase-one rise
// - Linear, interplane source: strobe addressed plane
// - Refresh/transfer high strobes every plane
// - Decode A17, A18, A22, A23 and status
// - Hold status copies during interplane source read
// - Direction high moves memory data to bus
// - Linear VRAM: addressed transceiver, direction read
// - Control register select: all enabled, low
// - Function select: selected transceivers, direction low
// - Interplane source: all enabled, source high
// - Other drawing accesses: transceivers disabled
`timescale 1ns/1ps
`include "vpc_map.svh"
module vpc_plane_controller (
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire logic                 phaseOneClock,
  input  wire logic                 columnStrobeInN,
  input  wire logic                 rowStrobeN,
  input  wire logic                 maskLatchStrobeN,
  input  wire logic                 refreshTransferActive,
  input  wire logic                 busStatusHigh,
  input  wire logic                 busStatusLow,
  input  wire logic                 bitbltStatusEnable,
  input  wire logic                 controlRegSelectN,
  input  wire vpc_pkg::vpc_planes_t functionSelectStrobeN,
  input  wire logic                 readN,
  input  wire logic [23:0]          address,
  input  wire logic [15:0]          data,
  output      vpc_pkg::vpc_planes_t planeColumnStrobeN,
  output      vpc_pkg::vpc_planes_t planeXcvrEnableN,
  output      vpc_pkg::vpc_planes_t planeXcvrDirection
);
  // Two-stage synchroniser on every pin
  vpc_pkg::vpc_pins_s pinsRaw;
  vpc_pkg::vpc_pins_s pinsMeta;
  vpc_pkg::vpc_pins_s pins;

  always_comb begin
    pinsRaw.phaseOneClock         = phaseOneClock;
    pinsRaw.columnStrobeInN       = columnStrobeInN;
    pinsRaw.rowStrobeN            = rowStrobeN;
    pinsRaw.maskLatchStrobeN      = maskLatchStrobeN;
    pinsRaw.refreshTransferActive = refreshTransferActive;
    pinsRaw.busStatusHigh         = busStatusHigh;
    pinsRaw.busStatusLow          = busStatusLow;
    pinsRaw.bitbltStatusEnable    = bitbltStatusEnable;
    pinsRaw.controlRegSelectN     = controlRegSelectN;
    pinsRaw.functionSelectStrobeN = functionSelectStrobeN;
    pinsRaw.readN                 = readN;
    pinsRaw.address               = address;
    pinsRaw.data                  = data;
  end

  // Idle pin levels: strobes and selects inactive
  localparam vpc_pkg::vpc_pins_s PinsIdle = '{
    phaseOneClock: 1'h0, columnStrobeInN: 1'h1, rowStrobeN: 1'h1,
    maskLatchStrobeN: 1'h1, refreshTransferActive: 1'h0,
    busStatusHigh: 1'h0, busStatusLow: 1'h0, bitbltStatusEnable: 1'h0,
    controlRegSelectN: 1'h1, functionSelectStrobeN: 4'hf, readN: 1'h1,
    address: 24'h000000, data: 16'h0000};

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pinsMeta <= PinsIdle;
      pins     <= PinsIdle;
    end else begin
      pinsMeta <= pinsRaw;
      pins     <= pinsMeta;
    end
  end

  // Edge detection on synchronised phase-one clock and latch strobe
  logic phaseOnePrev;
  logic maskLatchPrevN;
  logic phaseOneRise;
  logic maskLatchFall;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      phaseOnePrev   <= 1'h0;
      maskLatchPrevN <= 1'h1;
    end else begin
      phaseOnePrev   <= pins.phaseOneClock;
      maskLatchPrevN <= pins.maskLatchStrobeN;
    end
  end

  always_comb begin
    phaseOneRise  = pins.phaseOneClock & ~phaseOnePrev;
    maskLatchFall = ~pins.maskLatchStrobeN & maskLatchPrevN;
  end

  // Write mask and interplane flag, written by the processor
  vpc_pkg::vpc_planes_t writeMask;
  vpc_pkg::vpc_planes_t next_writeMask;
  logic                 interplane;
  logic                 next_interplane;

  always_comb begin
    next_writeMask  = writeMask;
    next_interplane = interplane;
    if (maskLatchFall) begin
      next_writeMask  = pins.data[`VPC_MASK_MSB:`VPC_MASK_LSB];
      next_interplane = pins.data[`VPC_INTERPLANE_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      writeMask  <= `VPC_MASK_RESET;
      interplane <= `VPC_INTERPLANE_RST;
    end else begin
      writeMask  <= next_writeMask;
      interplane <= next_interplane;
    end
  end

  // Status copy frozen while an interplane source read holds the row strobe
  vpc_pkg::vpc_status_s liveStatus;
  vpc_pkg::vpc_status_s heldStatus;
  vpc_pkg::vpc_status_s next_heldStatus;
  vpc_pkg::vpc_status_s useStatus;
  logic                 holding;
  logic                 next_holding;
  vpc_pkg::vpc_access_e access;

  always_comb begin
    liveStatus.busStatusHigh      = pins.busStatusHigh;
    liveStatus.busStatusLow       = pins.busStatusLow;
    liveStatus.bitbltStatusEnable = pins.bitbltStatusEnable;
    useStatus       = holding ? heldStatus : liveStatus;
    next_heldStatus = useStatus;
    next_holding    = holding;
    if (holding) begin
      next_holding = ~pins.rowStrobeN;
    end else if (!pins.rowStrobeN && access == vpc_pkg::VPC_ACC_INTERPLANE_SRC) begin
      next_holding = 1'h1;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      heldStatus <= '0;
      holding    <= 1'h0;
    end else begin
      heldStatus <= next_heldStatus;
      holding    <= next_holding;
    end
  end

  // Access decode
  vpc_pkg::vpc_planes_t strobeSelect;
  vpc_pkg::vpc_planes_t decEnableN;
  vpc_pkg::vpc_planes_t decDirection;

  vpc_plane_decode u_decode (
    .status                (useStatus),
    .interplane            (interplane),
    .writeMask             (writeMask),
    .address               (pins.address),
    .refreshTransferActive (pins.refreshTransferActive),
    .controlRegSelectN     (pins.controlRegSelectN),
    .functionSelectStrobeN (pins.functionSelectStrobeN),
    .readN                 (pins.readN),
    .access                (access),
    .strobeSelect          (strobeSelect),
    .enableN               (decEnableN),
    .direction             (decDirection)
  );

  // Output registers; plane strobes step only on phase-one rise
  vpc_pkg::vpc_drive_s drive;
  vpc_pkg::vpc_drive_s next_drive;

  always_comb begin
    next_drive               = drive;
    next_drive.xcvrEnableN   = decEnableN;
    next_drive.xcvrDirection = decDirection;
    if (phaseOneRise) begin
      if (pins.refreshTransferActive) begin
        next_drive.columnStrobeN = 4'h0;
      end else begin
        next_drive.columnStrobeN = ~(strobeSelect & {4{~pins.columnStrobeInN}});
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      drive <= '{columnStrobeN: 4'hf, xcvrEnableN: 4'hf, xcvrDirection: 4'h0};
    end else begin
      drive <= next_drive;
    end
  end

  always_comb begin
    planeColumnStrobeN = drive.columnStrobeN;
    planeXcvrEnableN   = drive.xcvrEnableN;
    planeXcvrDirection = drive.xcvrDirection;
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence maskWrite;
    maskLatchFall;
  endsequence

  sequence refreshEdge;
    phaseOneRise && pins.refreshTransferActive;
  endsequence

  sequence drawingEdge;
    phaseOneRise && !pins.refreshTransferActive
      && access == vpc_pkg::VPC_ACC_DRAWING;
  endsequence

  a_mask_capture: assert property (
    maskWrite |=> writeMask == $past(pins.data[3:0])
      && interplane == $past(pins.data[15]))
    else $error("Write mask not captured from data");

  a_mask_stable: assert property (
    !maskLatchFall |=> $stable(writeMask) && $stable(interplane))
    else $error("Write mask changed without latch strobe");

  a_refresh_all: assert property (
    refreshEdge |=> planeColumnStrobeN == 4'h0)
    else $error("Refresh did not strobe every plane");

  a_drawing_mask: assert property (
    drawingEdge |=> (~planeColumnStrobeN & ~$past(writeMask)) == 4'h0)
    else $error("Unmasked plane strobed during drawing");

  a_strobe_edge: assert property (
    !phaseOneRise |=> $stable(planeColumnStrobeN))
    else $error("Plane strobe changed off the phase-one edge");

  a_strobe_idle: assert property (
    phaseOneRise && pins.columnStrobeInN && !pins.refreshTransferActive
      |=> planeColumnStrobeN == 4'hf)
    else $error("Plane strobe active without column input");

  a_drawing_off: assert property (
    access == vpc_pkg::VPC_ACC_DRAWING |=> planeXcvrEnableN == 4'hf)
    else $error("Transceiver enabled during drawing access");

  a_ctrl_all: assert property (
    access == vpc_pkg::VPC_ACC_LINEAR && !pins.controlRegSelectN
      |=> planeXcvrEnableN == 4'h0 && planeXcvrDirection == 4'h0)
    else $error("Control register access did not enable all transceivers");

  a_src_dir: assert property (
    access == vpc_pkg::VPC_ACC_INTERPLANE_SRC
      |=> planeXcvrEnableN == 4'h0 && $onehot0(planeXcvrDirection))
    else $error("Interplane source read transceivers wrong");

  a_status_hold: assert property (
    holding && $past(holding) |-> heldStatus == $past(heldStatus))
    else $error("Held status changed during interplane source read");

  // Addressed plane, worked out apart from the decoder
  vpc_pkg::vpc_planes_t chkPlane;

  always_comb begin
    chkPlane = '0;
    if (!pins.address[`VPC_IO_SEL_BIT] && pins.address[`VPC_VRAM_SEL_BIT]) begin
      chkPlane[{pins.address[`VPC_PLANE_SEL_HI], pins.address[`VPC_PLANE_SEL_LO]}] = 1'h1;
    end
  end

  a_linear_strobe: assert property (
    phaseOneRise && !pins.refreshTransferActive && !pins.columnStrobeInN
      && access == vpc_pkg::VPC_ACC_LINEAR |=> planeColumnStrobeN == ~$past(chkPlane))
    else $error("Linear access strobed the wrong plane");

  a_linear_xcvr: assert property (
    access == vpc_pkg::VPC_ACC_LINEAR && pins.controlRegSelectN
      && pins.functionSelectStrobeN == 4'hf
      |=> planeXcvrEnableN == ~$past(chkPlane)
      && planeXcvrDirection == ($past(chkPlane) & {4{!$past(pins.readN)}}))
    else $error("Linear access transceiver wrong");

  a_func_select: assert property (
    access == vpc_pkg::VPC_ACC_LINEAR && pins.controlRegSelectN
      && pins.functionSelectStrobeN != 4'hf
      |=> planeXcvrEnableN == $past(pins.functionSelectStrobeN) && planeXcvrDirection == 4'h0)
    else $error("Function select transceivers wrong");

  a_src_plane: assert property (
    access == vpc_pkg::VPC_ACC_INTERPLANE_SRC |=> planeXcvrDirection == $past(chkPlane))
    else $error("Interplane source plane direction wrong");
endmodule : vpc_plane_controller

// [bench/vpc_bus_partner.sv]
// Processor and bus sequencer pin model driving the plane controller
`timescale 1ns/1ps
module vpc_bus_partner (
  input  wire logic                 core_clk,
  output wire logic                 phaseOneClock,
  output wire logic                 columnStrobeInN,
  output wire logic                 rowStrobeN,
  output wire logic                 maskLatchStrobeN,
  output wire logic                 refreshTransferActive,
  output wire logic                 busStatusHigh,
  output wire logic                 busStatusLow,
  output wire logic                 bitbltStatusEnable,
  output wire logic                 controlRegSelectN,
  output wire vpc_pkg::vpc_planes_t functionSelectStrobeN,
  output wire logic                 readN,
  output wire logic [23:0]          address,
  output wire logic [15:0]          data
);
  // Pin levels the model presents
  vpc_pkg::vpc_pins_s drv;

  assign phaseOneClock         = drv.phaseOneClock;
  assign columnStrobeInN       = drv.columnStrobeInN;
  assign rowStrobeN            = drv.rowStrobeN;
  assign maskLatchStrobeN      = drv.maskLatchStrobeN;
  assign refreshTransferActive = drv.refreshTransferActive;
  assign busStatusHigh         = drv.busStatusHigh;
  assign busStatusLow          = drv.busStatusLow;
  assign bitbltStatusEnable    = drv.bitbltStatusEnable;
  assign controlRegSelectN     = drv.controlRegSelectN;
  assign functionSelectStrobeN = drv.functionSelectStrobeN;
  assign readN                 = drv.readN;
  assign address               = drv.address;
  assign data                  = drv.data;

  // Idle: strobes and selects inactive
  initial begin
    drv = '{phaseOneClock: 1'h0, columnStrobeInN: 1'h1, rowStrobeN: 1'h1,
      maskLatchStrobeN: 1'h1, refreshTransferActive: 1'h0, busStatusHigh: 1'h1,
      busStatusLow: 1'h1, bitbltStatusEnable: 1'h0, controlRegSelectN: 1'h1,
      functionSelectStrobeN: 4'hf, readN: 1'h1, address: 24'h000000, data: 16'h0000};
  end

  // Every change lands 1 ns after a rising edge
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step

  task automatic set_access(input logic hi, input logic lo, input logic bitblt_status_enable,
                            input logic [23:0] addr, input logic rdN);
    step(1);
    drv.busStatusHigh      = hi;
    drv.busStatusLow       = lo;
    drv.bitbltStatusEnable = bitblt_status_enable;
    drv.address            = addr;
    drv.readN              = rdN;
    step(6);
  endtask : set_access

  task automatic set_ctrl(input logic rfa, input logic crN, input logic [3:0] function_select_strobe,
                          input logic rowN);
    step(1);
    drv.refreshTransferActive = rfa;
    drv.controlRegSelectN     = crN;
    drv.functionSelectStrobeN = function_select_strobe;
    drv.rowStrobeN            = rowN;
    step(6);
  endtask : set_ctrl

  task automatic mask_write(input logic [15:0] d);
    step(1);
    drv.address          = 24'he00007;
    drv.data             = d;
    drv.maskLatchStrobeN = 1'h0;
    step(6);
    drv.maskLatchStrobeN = 1'h1;
    step(6);
    drv.data = ~d;
  endtask : mask_write

  task automatic phase_strobe(input logic plane_column_strobe);
    step(1);
    drv.columnStrobeInN = plane_column_strobe;
    step(6);
    drv.phaseOneClock = 1'h1;
    step(6);
    drv.phaseOneClock   = 1'h0;
    drv.columnStrobeInN = 1'h1;
    step(4);
  endtask : phase_strobe
endmodule : vpc_bus_partner

// [bench/vpc_plane_controller_test.sv]
// Self-checking testbench for the plane controller
`timescale 1ns/1ps
module vpc_plane_controller_test;
  logic                 core_clk;
  logic                 reset;
  logic                 phaseOneClock, columnStrobeInN, rowStrobeN, maskLatchStrobeN;
  logic                 refreshTransferActive, busStatusHigh, busStatusLow;
  logic                 bitbltStatusEnable, controlRegSelectN, readN;
  vpc_pkg::vpc_planes_t functionSelectStrobeN;
  logic [23:0]          address;
  logic [15:0]          data;
  vpc_pkg::vpc_planes_t planeColumnStrobeN, planeXcvrEnableN, planeXcvrDirection;
  int                   errTotal;
  int                   nChecks;

  vpc_bus_partner i_vpc_bus_partner (.core_clk(core_clk), .phaseOneClock(phaseOneClock),
    .columnStrobeInN(columnStrobeInN), .rowStrobeN(rowStrobeN),
    .maskLatchStrobeN(maskLatchStrobeN), .refreshTransferActive(refreshTransferActive),
    .busStatusHigh(busStatusHigh), .busStatusLow(busStatusLow),
    .bitbltStatusEnable(bitbltStatusEnable), .controlRegSelectN(controlRegSelectN),
    .functionSelectStrobeN(functionSelectStrobeN), .readN(readN), .address(address),
    .data(data));

  vpc_plane_controller i_vpc_plane_controller (.core_clk(core_clk), .reset(reset),
    .phaseOneClock(phaseOneClock), .columnStrobeInN(columnStrobeInN),
    .rowStrobeN(rowStrobeN), .maskLatchStrobeN(maskLatchStrobeN),
    .refreshTransferActive(refreshTransferActive), .busStatusHigh(busStatusHigh),
    .busStatusLow(busStatusLow), .bitbltStatusEnable(bitbltStatusEnable),
    .controlRegSelectN(controlRegSelectN), .functionSelectStrobeN(functionSelectStrobeN),
    .readN(readN), .address(address), .data(data),
    .planeColumnStrobeN(planeColumnStrobeN), .planeXcvrEnableN(planeXcvrEnableN),
    .planeXcvrDirection(planeXcvrDirection));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic check(input string name, input logic [3:0] exp, input logic [3:0] got);
    nChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : check

  task automatic endOfTest;
    $display("checks %0d, mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : endOfTest

  task automatic test_reset;
    i_vpc_bus_partner.phase_strobe(1'b0);
    check("reset strobe", 4'hf, planeColumnStrobeN);
    check("reset enable", 4'hf, planeXcvrEnableN);
    $display("test reset done");
  endtask : test_reset

  task automatic test_mask_draw;
    i_vpc_bus_partner.mask_write(16'h7ff5);
    i_vpc_bus_partner.set_access(1'b1, 1'b1, 1'b0, 24'h420000, 1'b0);
    i_vpc_bus_partner.phase_strobe(1'b0);
    check("draw strobe", 4'ha, planeColumnStrobeN);
    check("draw enable", 4'hf, planeXcvrEnableN);
    i_vpc_bus_partner.phase_strobe(1'b1);
    check("draw idle strobe", 4'hf, planeColumnStrobeN);
    $display("test mask_draw done");
  endtask : test_mask_draw

  task automatic test_linear;
    logic [3:0] sel;
    for (int p = 0; p < 4; p++) begin
      sel = 4'h1 << p;
      i_vpc_bus_partner.set_access(1'b0, 1'b0, 1'b0, {5'h08, 2'(p), 17'h0}, 1'b0);
      i_vpc_bus_partner.phase_strobe(1'b0);
      check("linear strobe", ~sel, planeColumnStrobeN);
      check("linear enable", ~sel, planeXcvrEnableN);
      check("linear read dir", sel, planeXcvrDirection);
      i_vpc_bus_partner.set_access(1'b0, 1'b0, 1'b0, {5'h08, 2'(p), 17'h0}, 1'b1);
      check("linear write dir", 4'h0, planeXcvrDirection);
    end
    $display("test linear done");
  endtask : test_linear

  task automatic test_selects;
    i_vpc_bus_partner.set_access(1'b0, 1'b0, 1'b0, 24'h000000, 1'b0);
    i_vpc_bus_partner.set_ctrl(1'b0, 1'b0, 4'hf, 1'b1);
    check("ctrl enable", 4'h0, planeXcvrEnableN);
    check("ctrl dir", 4'h0, planeXcvrDirection);
    i_vpc_bus_partner.set_ctrl(1'b0, 1'b1, 4'h5, 1'b1);
    check("func enable", 4'h5, planeXcvrEnableN);
    check("func dir", 4'h0, planeXcvrDirection);
    i_vpc_bus_partner.set_ctrl(1'b0, 1'b1, 4'hf, 1'b1);
    $display("test selects done");
  endtask : test_selects

  task automatic test_refresh;
    i_vpc_bus_partner.mask_write(16'h0000);
    i_vpc_bus_partner.set_access(1'b1, 1'b1, 1'b0, 24'h400000, 1'b0);
    i_vpc_bus_partner.set_ctrl(1'b1, 1'b1, 4'hf, 1'b1);
    i_vpc_bus_partner.phase_strobe(1'b0);
    check("refresh strobe", 4'h0, planeColumnStrobeN);
    i_vpc_bus_partner.phase_strobe(1'b1);
    check("refresh held strobe", 4'h0, planeColumnStrobeN);
    i_vpc_bus_partner.set_ctrl(1'b0, 1'b1, 4'hf, 1'b1);
    i_vpc_bus_partner.phase_strobe(1'b0);
    check("after refresh strobe", 4'hf, planeColumnStrobeN);
    $display("test refresh done");
  endtask : test_refresh

  task automatic test_interplane;
    i_vpc_bus_partner.mask_write(16'h8003);
    i_vpc_bus_partner.set_access(1'b1, 1'b0, 1'b1, 24'h440000, 1'b0);
    i_vpc_bus_partner.phase_strobe(1'b0);
    check("source strobe", 4'hb, planeColumnStrobeN);
    check("source enable", 4'h0, planeXcvrEnableN);
    check("source dir", 4'h4, planeXcvrDirection);
    i_vpc_bus_partner.set_ctrl(1'b0, 1'b1, 4'hf, 1'b0);
    i_vpc_bus_partner.set_access(1'b1, 1'b1, 1'b0, 24'h440000, 1'b0);
    check("held enable", 4'h0, planeXcvrEnableN);
    check("held dir", 4'h4, planeXcvrDirection);
    i_vpc_bus_partner.phase_strobe(1'b0);
    check("held strobe", 4'hb, planeColumnStrobeN);
    i_vpc_bus_partner.set_ctrl(1'b0, 1'b1, 4'hf, 1'b1);
    check("drawing enable", 4'hf, planeXcvrEnableN);
    i_vpc_bus_partner.phase_strobe(1'b0);
    check("drawing strobe", 4'hc, planeColumnStrobeN);
    $display("test interplane done");
  endtask : test_interplane

  // Reset in mid-run must drop the mask and the interplane flag
  task automatic test_reset_mid;
    @(posedge core_clk);
    #1 reset = 1'b1;
    repeat (3) @(posedge core_clk);
    #1 reset = 1'b0;
    i_vpc_bus_partner.set_access(1'b1, 1'b0, 1'b1, 24'h440000, 1'b0);
    i_vpc_bus_partner.phase_strobe(1'b0);
    check("reset mask strobe", 4'hf, planeColumnStrobeN);
    check("reset flag enable", 4'hf, planeXcvrEnableN);
    $display("test reset_mid done");
  endtask : test_reset_mid

  initial begin
    errTotal = 0;
    nChecks = 0;
    reset = 1'b1;
    repeat (5) @(posedge core_clk);
    #1 reset = 1'b0;
    test_reset();
    test_mask_draw();
    test_linear();
    test_selects();
    test_refresh();
    test_interplane();
    test_reset_mid();
    endOfTest();
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    errTotal++;
    endOfTest();
  end
endmodule : vpc_plane_controller_test
